// File: design/swc_top.sv
// Sleep and wake-up sequencer for a small microcontroller core
//
// Design decisions made here: the APB register port and the register offsets.
`timescale 1ns/1ns
// Operation
// RL1: With interrupts globally off, a source with enable and flag set is a pending wake.
// RL2: A wake pending before sleep makes sleep a no-operation.
// RL3: A no-operation sleep leaves watchdog and both status bits untouched.
// RL4: A wake arising during or after sleep ends sleep at once.
// RL5: Sleep runs fully first: watchdog cleared, time-out set, power-down cleared.
// RL6: Software reads power-down status to see if sleep was skipped.
// RL7: Software should clear the watchdog just before sleeping.
// RL8: Crystal modes wait 1024 oscillator periods on wake; RC modes skip it.
// RL9: With global enable set, branch to vector 0004h after the next instruction.
// RL10: With global enable clear, continue in line with no branch.
// RL11: No instruction clock out in crystal, high-speed or low-power modes.
// RL12: Entering sleep clears watchdog, sets time-out, clears power-down, stops driver.
// RL13: Wake needs the source enable and ignores global enable.
// RL14: The prefetched instruction after sleep runs before any vector branch.
// RL15: A vector branch inserts two idle instruction cycles.
module swc_top
  import swc_pkg::*;
#(
  parameter int OST_CYCLES = SWC_OST_CYCLES
)(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sleep_instr,
  input wire logic watchdog_clear_instr,
  input wire logic watchdog_timeout,
  input wire logic instr_done,
  input wire logic [SWC_IRQ_SRCS-1:0] irq_flag,
  output logic cpu_stall_ff,
  output logic instr_clock_output_ff,
  output logic osc_driver_on_ff,
  output logic watchdog_clear_ff,
  output logic vector_load_ff,
  output logic [12:0] vector_addr_ff,
  output logic exec_idle_ff,
  output logic timeout_status_n_ff,
  output logic powerdown_status_n_ff
);
  if (OST_CYCLES < 1 || OST_CYCLES > 65535) begin : g_ost_range
    $error("OST_CYCLES range");
  end
  swc_apb_if rif ();
  swc_regs u_regs (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .clk_en(clk_en),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rif(rif)
  );
  swc_state_t state_ff, nxt_state;
  logic [15:0] cnt_ff;
  logic [SWC_IRQ_SRCS-1:0] flag_s1_ff, flag_s2_ff;
  logic wd_s1_ff, wd_s2_ff;
  logic [7:0] stat;
  logic wake, crystal, vec_pending_ff;
  function automatic logic is_crystal(input logic [2:0] m);
    is_crystal = m == SWC_OSC_LP || m == SWC_OSC_XT || m == SWC_OSC_HS;
  endfunction
  // Flags and watchdog expiry come from other domains: two stages first
  // Watchdog pulse must last a full clock or it may be missed
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      flag_s1_ff <= '0;
      flag_s2_ff <= '0;
      wd_s1_ff <= 1'b0;
      wd_s2_ff <= 1'b0;
    end else if (clk_en) begin
      flag_s1_ff <= irq_flag;
      flag_s2_ff <= flag_s1_ff;
      wd_s1_ff <= watchdog_timeout;
      wd_s2_ff <= wd_s1_ff;
    end
  end
  // Global enable ignored: only source enable and flag matter [RL1] [RL13]
  assign wake = |(flag_s2_ff & rif.irq_en);
  assign crystal = is_crystal(rif.osc_mode);
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      SWC_RUN:
        if (sleep_instr && !wake) nxt_state = SWC_SLEEP; // [RL2]
      SWC_SLEEP:
        if (wake || wd_s2_ff) begin // [RL4]
          nxt_state = crystal ? SWC_OST : SWC_NEXT; // [RL8]
        end
      SWC_OST:
        if (cnt_ff == 16'(OST_CYCLES - 1)) nxt_state = SWC_NEXT; // [RL8]
      SWC_NEXT:
        if (instr_done) begin // [RL14]
          nxt_state = vec_pending_ff ? SWC_DUMMY : SWC_RUN; // [RL9] [RL10]
        end
      SWC_DUMMY:
        if (cnt_ff == 16'(SWC_DUMMY_CYCLES - 1)) nxt_state = SWC_RUN;
      default: nxt_state = SWC_RUN;
    endcase
  end
  always_ff @(posedge sys_clk) begin
    if (sys_rst) state_ff <= SWC_RUN;
    else if (clk_en) state_ff <= nxt_state;
  end
  always_ff @(posedge sys_clk) begin
    if (sys_rst) cnt_ff <= 16'h0;
    else if (clk_en) begin
      if (nxt_state != state_ff) cnt_ff <= 16'h0;
      else cnt_ff <= cnt_ff + 16'h1;
    end
  end
  // Vector choice is latched at wake so a late enable change cannot split it
  always_ff @(posedge sys_clk) begin
    if (sys_rst) vec_pending_ff <= 1'b0;
    else if (clk_en && state_ff == SWC_SLEEP && nxt_state != SWC_SLEEP) begin
      vec_pending_ff <= rif.global_irq_enable && wake; // [RL9] [RL10]
    end
  end
  // Status bits: sleep entry updates them, a skipped sleep does not
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      timeout_status_n_ff <= 1'b1;
      powerdown_status_n_ff <= 1'b1;
    end else if (clk_en) begin
      if (state_ff == SWC_RUN && sleep_instr && !wake) begin
        timeout_status_n_ff <= 1'b1; // [RL5] [RL12] [RL3]
        powerdown_status_n_ff <= 1'b0; // [RL5] [RL12] [RL3]
      end else if (watchdog_clear_instr || wd_s2_ff) begin
        // Expiry wins over a clear arriving in the same cycle
        timeout_status_n_ff <= !wd_s2_ff;
        if (watchdog_clear_instr) powerdown_status_n_ff <= 1'b1;
      end
    end
  end
  always_comb begin
    stat = 8'h00;
    stat[SWC_STAT_PD_BIT] = powerdown_status_n_ff;
    stat[SWC_STAT_TO_BIT] = timeout_status_n_ff;
    stat[SWC_STAT_SLEEP_BIT] = state_ff == SWC_SLEEP;
    stat[SWC_STAT_DELAY_BIT] = state_ff == SWC_OST;
  end
  assign rif.stat = stat;
  always_ff @(posedge sys_clk) begin
    if (sys_rst) watchdog_clear_ff <= 1'b0;
    else if (clk_en) begin
      watchdog_clear_ff <= watchdog_clear_instr ||
        (state_ff == SWC_RUN && sleep_instr && !wake); // [RL5] [RL3] [RL12]
    end
  end
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      cpu_stall_ff <= 1'b0;
      osc_driver_on_ff <= 1'b1;
      exec_idle_ff <= 1'b0;
      vector_load_ff <= 1'b0;
      vector_addr_ff <= 13'h0000;
    end else if (clk_en) begin
      cpu_stall_ff <= nxt_state == SWC_SLEEP || nxt_state == SWC_OST;
      osc_driver_on_ff <= nxt_state != SWC_SLEEP; // [RL12]
      exec_idle_ff <= nxt_state == SWC_DUMMY; // [RL15]
      vector_load_ff <= state_ff == SWC_DUMMY && nxt_state == SWC_RUN;
      vector_addr_ff <= SWC_IRQ_VECTOR; // [RL9]
    end
  end
  // Divider stands in for the instruction clock; quiet in crystal modes
  logic [1:0] q_ff;
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      q_ff <= 2'h0;
      instr_clock_output_ff <= 1'b0;
    end else if (clk_en) begin
      q_ff <= q_ff + 2'h1;
      instr_clock_output_ff <= !crystal && q_ff[1] &&
                               state_ff != SWC_SLEEP; // [RL11]
    end
  end
  property p_rl2;
    @(posedge sys_clk) disable iff (sys_rst)
      clk_en && state_ff == SWC_RUN && sleep_instr && wake
      |=> state_ff == SWC_RUN;
  endproperty
  a_rl2: assert property (p_rl2) else $error("sleep not skipped"); // [RL2]
  property p_rl3;
    @(posedge sys_clk) disable iff (sys_rst)
      clk_en && state_ff == SWC_RUN && sleep_instr && wake &&
      !watchdog_clear_instr |=> !watchdog_clear_ff;
  endproperty
  a_rl3: assert property (p_rl3) else $error("skip cleared dog"); // [RL3]
  property p_rl5;
    @(posedge sys_clk) disable iff (sys_rst)
      clk_en && state_ff == SWC_RUN && sleep_instr && !wake
      |=> !powerdown_status_n_ff && timeout_status_n_ff && watchdog_clear_ff;
  endproperty
  a_rl5: assert property (p_rl5) else $error("sleep entry bits"); // [RL5]
  property p_rl4;
    @(posedge sys_clk) disable iff (sys_rst)
      clk_en && state_ff == SWC_SLEEP && wake |=> state_ff != SWC_SLEEP;
  endproperty
  a_rl4: assert property (p_rl4) else $error("no wake"); // [RL4]
  property p_rl8;
    @(posedge sys_clk) disable iff (sys_rst)
      state_ff == SWC_SLEEP && $past(state_ff) == SWC_SLEEP && clk_en &&
      wake && !crystal |=> state_ff == SWC_NEXT;
  endproperty
  a_rl8: assert property (p_rl8) else $error("rc delay"); // [RL8]
  property p_rl11;
    @(posedge sys_clk) disable iff (sys_rst)
      crystal && $past(crystal) |-> !instr_clock_output_ff;
  endproperty
  a_rl11: assert property (p_rl11) else $error("clock out"); // [RL11]
  property p_rl12;
    @(posedge sys_clk) disable iff (sys_rst)
      state_ff == SWC_SLEEP && $past(state_ff) == SWC_SLEEP
      |-> !osc_driver_on_ff;
  endproperty
  a_rl12: assert property (p_rl12) else $error("driver on"); // [RL12]
  property p_rl15;
    @(posedge sys_clk) disable iff (sys_rst)
      $rose(exec_idle_ff) && clk_en |=> exec_idle_ff;
  endproperty
  a_rl15: assert property (p_rl15) else $error("idle short"); // [RL15]
  property p_rl10;
    @(posedge sys_clk) disable iff (sys_rst)
      clk_en && state_ff == SWC_NEXT && instr_done && !vec_pending_ff
      |=> state_ff == SWC_RUN;
  endproperty
  a_rl10: assert property (p_rl10) else $error("branch taken"); // [RL10]
  // Skipped sleep, sleep entry, wake paths and vector branch
  property p_rl1;
    @(posedge sys_clk) disable iff (sys_rst)
      clk_en && state_ff == SWC_RUN && sleep_instr &&
      !watchdog_clear_instr && !rif.global_irq_enable &&
      |(flag_s2_ff & rif.irq_en)
      |=> state_ff == SWC_RUN && $stable(powerdown_status_n_ff);
  endproperty
  a_rl1: assert property (p_rl1) else $error("pending ignored"); // [RL1]
  property p_rl3s;
    @(posedge sys_clk) disable iff (sys_rst)
      clk_en && state_ff == SWC_RUN && sleep_instr && wake &&
      !watchdog_clear_instr && !wd_s2_ff
      |=> $stable(timeout_status_n_ff) && $stable(powerdown_status_n_ff);
  endproperty
  a_rl3s: assert property (p_rl3s) else $error("skip status"); // [RL3]
  property p_rl13w;
    @(posedge sys_clk) disable iff (sys_rst)
      clk_en && state_ff == SWC_SLEEP && |(flag_s2_ff & rif.irq_en) &&
      !rif.global_irq_enable |=> state_ff != SWC_SLEEP;
  endproperty
  a_rl13w: assert property (p_rl13w) else $error("gie blocked"); // [RL13]
  property p_rl13e;
    @(posedge sys_clk) disable iff (sys_rst)
      clk_en && state_ff == SWC_SLEEP && !(|(flag_s2_ff & rif.irq_en)) &&
      !wd_s2_ff |=> state_ff == SWC_SLEEP;
  endproperty
  a_rl13e: assert property (p_rl13e) else $error("woke unenabled"); // [RL13]
  property p_rl14;
    @(posedge sys_clk) disable iff (sys_rst)
      clk_en && state_ff == SWC_NEXT && !instr_done
      |=> state_ff == SWC_NEXT && !vector_load_ff;
  endproperty
  a_rl14: assert property (p_rl14) else $error("early vector"); // [RL14]
  property p_rl9;
    @(posedge sys_clk) disable iff (sys_rst)
      vector_load_ff |-> vector_addr_ff == SWC_IRQ_VECTOR &&
      state_ff == SWC_RUN;
  endproperty
  a_rl9: assert property (p_rl9) else $error("vector wrong"); // [RL9]
  property p_rl15e;
    @(posedge sys_clk) disable iff (sys_rst)
      clk_en && $past(clk_en) && exec_idle_ff && $past(exec_idle_ff)
      |=> !exec_idle_ff;
  endproperty
  a_rl15e: assert property (p_rl15e) else $error("idle long"); // [RL15]
  property p_rl8x;
    @(posedge sys_clk) disable iff (sys_rst)
      clk_en && state_ff == SWC_SLEEP && wake && crystal
      |=> state_ff == SWC_OST && cpu_stall_ff;
  endproperty
  a_rl8x: assert property (p_rl8x) else $error("no delay"); // [RL8]
  property p_rl12e;
    @(posedge sys_clk) disable iff (sys_rst)
      clk_en && state_ff == SWC_RUN && sleep_instr && !wake
      |=> state_ff == SWC_SLEEP && !osc_driver_on_ff;
  endproperty
  a_rl12e: assert property (p_rl12e) else $error("driver kept"); // [RL12]
  property p_rl10n;
    @(posedge sys_clk) disable iff (sys_rst)
      clk_en && state_ff == SWC_NEXT && instr_done && !vec_pending_ff
      |=> !exec_idle_ff && !vector_load_ff;
  endproperty
  a_rl10n: assert property (p_rl10n) else $error("idle taken"); // [RL10]
  c_sleep: cover property (@(posedge sys_clk) state_ff == SWC_SLEEP);
  c_skip: cover property (@(posedge sys_clk)
    state_ff == SWC_RUN && sleep_instr && wake);
  c_idle: cover property (@(posedge sys_clk)
    exec_idle_ff);
  c_ost: cover property (@(posedge sys_clk) state_ff == SWC_OST);
  c_vec: cover property (@(posedge sys_clk) vector_load_ff);
endmodule

// File: design/swc_pkg.sv
// Constants and types for the sleep and wake-up controller
package swc_pkg;
  localparam logic [1:0] SWC_APB_ADDR_LSB = 2'h0;
  localparam logic [11:0] SWC_CTRL_OFS = 12'h000;
  localparam logic [11:0] SWC_STAT_OFS = 12'h004;
  localparam logic [11:0] SWC_IRQ_OFS = 12'h008;
  localparam int SWC_CTRL_GIE_BIT = 0;
  localparam int SWC_CTRL_OSC_LSB = 1;
  localparam int SWC_STAT_PD_BIT = 0;
  localparam int SWC_STAT_TO_BIT = 1;
  localparam int SWC_STAT_SLEEP_BIT = 2;
  localparam int SWC_STAT_DELAY_BIT = 3;
  localparam int SWC_CLK_MHZ = 125;
  localparam int SWC_OST_TOSC = 1024;
  localparam int SWC_OST_CYCLES = SWC_OST_TOSC;
  localparam int SWC_DUMMY_CYCLES = 2;
  localparam logic [12:0] SWC_IRQ_VECTOR = 13'h0004;
  localparam int SWC_IRQ_SRCS = 4;
  typedef enum logic [2:0] {
    SWC_OSC_LP = 3'h0,
    SWC_OSC_XT = 3'h1,
    SWC_OSC_HS = 3'h2,
    SWC_OSC_INTERNAL_RC_OSC_MODE = 3'h4,
    SWC_OSC_EXTERNAL_RC_OSC_MODE = 3'h6
  } swc_osc_t;
  typedef enum logic [2:0] {
    SWC_RUN = 3'h0,
    SWC_SLEEP = 3'h1,
    SWC_OST = 3'h2,
    SWC_NEXT = 3'h3,
    SWC_DUMMY = 3'h4
  } swc_state_t;
endpackage

// File: design/swc_apb_if.sv
// APB-side register signals between the top and the register block
`timescale 1ns/1ns
interface swc_apb_if;
  logic global_irq_enable;
  logic [2:0] osc_mode;
  logic [7:0] stat;
  logic [3:0] irq_en;
  modport regs (output global_irq_enable, osc_mode, irq_en, input stat);
  modport core (input global_irq_enable, osc_mode, irq_en, output stat);
endinterface

// File: design/swc_regs.sv
// APB register block of the sleep and wake-up controller
`timescale 1ns/1ns
module swc_regs
  import swc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  swc_apb_if.regs rif
);
  logic [3:0] ctrl_ff;
  logic [3:0] irq_en_ff;
  logic [31:0] prdata_ff;
  logic pslverr_ff;
  logic pready_ff;
  logic access;
  logic mapped;
  assign access = psel && penable && !pready_ff;
  assign mapped = paddr == SWC_CTRL_OFS || paddr == SWC_STAT_OFS ||
                  paddr == SWC_IRQ_OFS;
  // One wait state keeps read data registered
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0;
    end else if (clk_en) begin
      pready_ff <= access;
      pslverr_ff <= access && !mapped;
      if (access && !pwrite) begin
        case (paddr)
          SWC_CTRL_OFS: prdata_ff <= {28'h0, ctrl_ff};
          SWC_STAT_OFS: prdata_ff <= {24'h0, rif.stat};
          SWC_IRQ_OFS: prdata_ff <= {28'h0, irq_en_ff};
          default: prdata_ff <= 32'h0;
        endcase
      end
    end
  end
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ctrl_ff <= 4'h0;
      irq_en_ff <= 4'h0;
    end else if (clk_en && psel && penable && pready_ff && pwrite) begin
      // Write lands on the edge where the master sees ready high
      if (paddr == SWC_CTRL_OFS) ctrl_ff <= pwdata[3:0];
      if (paddr == SWC_IRQ_OFS) irq_en_ff <= pwdata[3:0];
    end
  end
  assign rif.global_irq_enable = ctrl_ff[SWC_CTRL_GIE_BIT];
  assign rif.osc_mode = ctrl_ff[SWC_CTRL_OSC_LSB +: 3];
  assign rif.irq_en = irq_en_ff;
  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
endmodule

// File: test/swc_partner.sv
// Model of the interrupt sources and the watchdog beside the controller
`timescale 1ns/1ns
module swc_partner (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [3:0] raise,
  input wire logic [3:0] lower,
  input wire logic dog_fire,
  output logic [3:0] irq_flag,
  output logic watchdog_timeout
);
  // Flags set whatever the enables say; software must clear them
  always_ff @(posedge sys_clk) begin
    if (sys_rst) irq_flag <= 4'h0;
    else irq_flag <= (irq_flag | raise) & ~lower;
  end
  always_ff @(posedge sys_clk) begin
    watchdog_timeout <= sys_rst ? 1'b0 : dog_fire;
  end
endmodule

// File: test/swc_top_tb.sv
// Self-checking bench for the sleep and wake-up controller
`timescale 1ns/1ns
module swc_top_tb;
  import swc_pkg::*;
  // Start-up delay shortened, but above any RC wake latency
  localparam int OST = 16;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, wd_to, stall, ck_out, drv, dclr, vld;
  logic idle, to_n, pd_n, last_ck;
  logic slp = 1'b0, wclr = 1'b0, idone = 1'b0, fire = 1'b0;
  logic [3:0] raise = 4'h0, lower = 4'h0, flag;
  logic [12:0] vec, va;
  int n_errors = 0, checked = 0, cyc = 0, c, nd, ni, nv, nt;
  always #4 sys_clk = ~sys_clk;
  swc_partner i_part (.sys_clk(sys_clk), .sys_rst(sys_rst), .raise(raise),
    .lower(lower), .dog_fire(fire), .irq_flag(flag),
    .watchdog_timeout(wd_to));
  swc_top #(.OST_CYCLES(OST)) i_dut (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .clk_en(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sleep_instr(slp), .watchdog_clear_instr(wclr),
    .watchdog_timeout(wd_to), .instr_done(idone), .irq_flag(flag),
    .cpu_stall_ff(stall), .instr_clock_output_ff(ck_out),
    .osc_driver_on_ff(drv), .watchdog_clear_ff(dclr),
    .vector_load_ff(vld), .vector_addr_ff(vec), .exec_idle_ff(idle),
    .timeout_status_n_ff(to_n), .powerdown_status_n_ff(pd_n));
  // Event counters sampled mid-cycle, away from the launching edge
  always @(negedge sys_clk) begin
    cyc++;
    if (dclr === 1'b1) nd++;
    if (idle === 1'b1) ni++;
    if (ck_out !== last_ck) nt++;
    last_ck = ck_out;
    if (vld === 1'b1) begin
      nv++;
      va = vec;
    end
    if (cyc == 20000) begin
      n_errors++;
      results();
    end
  end
  task results;
    $display("mismatches %0d of %0d checks", n_errors, checked);
    if (n_errors == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task pulse_sleep;
    @(posedge sys_clk) slp <= 1'b1;
    @(posedge sys_clk) slp <= 1'b0;
    repeat (3) @(posedge sys_clk);
  endtask
  task flag_up(input logic up);
    @(posedge sys_clk) if (up) raise <= 4'h1; else lower <= 4'hF;
    @(posedge sys_clk) begin raise <= 4'h0; lower <= 4'h0; end
  endtask
  task wait_wake;
    for (c = 0; c < 3000 && stall === 1'b1; c++) @(posedge sys_clk);
  endtask
  task t_regs;
    apb(1'b1, SWC_IRQ_OFS, 32'h1);
    apb(1'b0, SWC_IRQ_OFS, 32'h0);
    chk(rd, 32'h1);
    apb(1'b0, 12'h00C, 32'h0);
    chk(err, 1'b1);
    chk(rd, 32'h0);
    apb(1'b1, SWC_CTRL_OFS, 32'h8);
    apb(1'b0, SWC_CTRL_OFS, 32'h0);
    chk(rd, 32'h8);
  endtask
  task t_nop;
    @(posedge sys_clk) wclr <= 1'b1;
    @(posedge sys_clk) wclr <= 1'b0;
    @(posedge sys_clk) fire <= 1'b1;
    @(posedge sys_clk) fire <= 1'b0;
    flag_up(1'b1);
    repeat (4) @(posedge sys_clk);
    c = nd;
    pulse_sleep();
    chk(pd_n, 1'b1);
    chk({to_n, stall, drv}, 3'b001);
    chk(nd, c);
    apb(1'b0, SWC_STAT_OFS, 32'h0);
    chk(rd[SWC_STAT_PD_BIT], 1'b1);
    flag_up(1'b0);
  endtask
  task t_rc;
    c = nt;
    repeat (20) @(posedge sys_clk);
    chk(nt > c, 1'b1);
    c = nd;
    pulse_sleep();
    chk({pd_n, to_n, drv, stall, nd > c}, 5'b01011);
    apb(1'b0, SWC_STAT_OFS, 32'h0);
    chk(rd[SWC_STAT_PD_BIT], 1'b0);
    chk(rd[SWC_STAT_SLEEP_BIT], 1'b1);
    @(posedge sys_clk) raise <= 4'h2;
    @(posedge sys_clk) raise <= 4'h0;
    repeat (6) @(posedge sys_clk);
    chk(stall, 1'b1);
    flag_up(1'b1);
    wait_wake();
    chk(c < 8, 1'b1);
    c = nv;
    @(posedge sys_clk) idone <= 1'b1;
    @(posedge sys_clk) idone <= 1'b0;
    repeat (8) @(posedge sys_clk);
    chk(nv, c);
    flag_up(1'b0);
  endtask
  task t_xtal;
    apb(1'b1, SWC_CTRL_OFS, 32'h3);
    repeat (4) @(posedge sys_clk);
    c = nt;
    repeat (20) @(posedge sys_clk);
    chk({nt == c, ck_out}, 2'b10);
    pulse_sleep();
    flag_up(1'b1);
    wait_wake();
    chk(c >= OST && c < OST + 8, 1'b1);
    c = nv;
    ni = 0;
    repeat (6) @(posedge sys_clk);
    chk(nv, c);
    @(posedge sys_clk) idone <= 1'b1;
    @(posedge sys_clk) idone <= 1'b0;
    repeat (8) @(posedge sys_clk);
    chk(ni, 2);
    chk(nv, c + 1);
    chk(va, 13'h0004);
    flag_up(1'b0);
  endtask
  initial begin
    repeat (20) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    chk({to_n, pd_n, drv, stall}, 4'hE);
    t_regs();
    t_nop();
    t_rc();
    t_xtal();
    results();
  end
endmodule
